// File: design/sideband_pkg.sv
package sideband_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFF_HIMR = 8'h10;

  // Host interrupt mask register fields
  localparam int ROUTE_LSB = 8;
  localparam int ROUTE_MSB = 9;
  localparam logic [31:0] HIMR_RST = 32'h0000_0000;

  // Route encodings
  localparam logic [1:0] ROUTE_STD = 2'h0;
  localparam logic [1:0] ROUTE_ALT = 2'h1;
  localparam logic [1:0] ROUTE_BOTH = 2'h2;

  // Control register fields
  localparam int CTRL_LED = 0;
  localparam int CTRL_EVT_CLR = 1;
  localparam int CTRL_SRC_IRQ = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  // Sticky event bits
  localparam int EV_LEVER_RISE = 0;
  localparam int EV_LEVER_FALL = 1;
  localparam int EV_CFG_BLOCK = 2;
  localparam int EV_W = 3;
  localparam logic [EV_W-1:0] EV_RST = 3'h0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic zcr_n;
    logic cpci_n;
    logic wide_n;
  } strap_t;

  typedef struct packed {
    logic inta_n;
    logic alt_irq_oe;
    logic event_oe;
    logic led_n;
    logic cfg_ok;
    logic grant;
  } pins_out_t;

endpackage

// File: design/sync2.sv
`timescale 1ns/1ps
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  // A zero-width bus has nothing to carry
  if (W < 1)
  begin : g_width_check
    $error("sync2 needs a width of at least one");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      meta_r <= '0;
      q_o <= '0;
    end
    else
    begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule

// File: design/pci_sideband_zcr_hotswap.sv
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module pci_sideband_zcr_hotswap (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Mode straps
  input wire logic zero_chan_raid_en_n_i,
  input wire logic compact_bus_en_n_i,
  input wire logic wide_bus_en_n_i,
  // Arbitration and config
  input wire logic std_grant_n_i,
  input wire logic alt_grant_n_i,
  input wire logic cfg_cycle_i,
  output logic cfg_accept_o,
  output logic bus_grant_o,
  // Hot-swap
  input wire logic hotswap_lever_i,
  input wire logic hotswap_event_n_i,
  output logic hotswap_event_n_o,
  output logic hotswap_event_n_oe_o,
  output logic blue_status_led_n_o,
  output logic wide_bus_o,
  output logic compact_mode_o,
  // Interrupt request from core and pins
  input wire logic dev_irq_i,
  output logic inta_n_o,
  output logic alt_irq_n_o,
  output logic alt_irq_n_oe_o,
  output logic irq_o,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARMED = 2'b01,
    ST_STRAPPED = 2'b10
  } strap_st_t;

  typedef struct packed {
    strap_st_t st;
    sideband_pkg::strap_t strap;
    logic lever_d;
    logic event_held;
    logic led;
    logic src_irq;
    logic [1:0] route;
    logic [sideband_pkg::EV_W-1:0] ev;
    logic [sideband_pkg::EV_W-1:0] mask;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    sideband_pkg::pins_out_t po;
    logic irq;
  } state_t;

  state_t s_r;
  state_t s_nxt;
  logic rst_meta_r;
  logic rst_n_r;
  logic [6:0] pins_s;

  // Reset released through two flops
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  // Pins cross into clock domain
  sync2 #(
    .W(7)
  ) u_sync (
    .clk_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .d_i({hotswap_event_n_i, zero_chan_raid_en_n_i, compact_bus_en_n_i,
          wide_bus_en_n_i, std_grant_n_i, alt_grant_n_i, hotswap_lever_i}),
    .q_o(pins_s)
  );

  function automatic logic [31:0] wmerge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb
  begin
    logic [31:0] ctrl;
    logic [31:0] himr;
    logic [31:0] wv;
    logic [sideband_pkg::EV_W-1:0] set;
    logic zcr;
    logic cpci;
    logic grant_alt;
    logic grant_std;
    logic route_std;
    logic route_alt;
    logic irq_req;
    logic do_w;
    logic do_r;
    ctrl = '0;
    himr = '0;
    wv = '0;
    set = '0;
    s_nxt = s_r;
    zcr = !s_r.strap.zcr_n;
    cpci = !s_r.strap.cpci_n;
    grant_alt = !pins_s[1];
    grant_std = !pins_s[2];
    do_w = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    do_r = s_axi_arvalid && !s_r.rvalid;
    irq_req = dev_irq_i || s_r.src_irq;
    route_std = !zcr || s_r.route == sideband_pkg::ROUTE_STD
                || s_r.route == sideband_pkg::ROUTE_BOTH;
    route_alt = s_r.route == sideband_pkg::ROUTE_ALT
                || s_r.route == sideband_pkg::ROUTE_BOTH;

    // Straps caught once after reset release, then frozen
    case (s_r.st)
      ST_IDLE: s_nxt.st = ST_ARMED;
      ST_ARMED:
      begin
        s_nxt.strap = '{zcr_n: pins_s[5], cpci_n: pins_s[4],
                        wide_n: pins_s[3]};
        s_nxt.st = ST_STRAPPED;
      end
      ST_STRAPPED: s_nxt.st = ST_STRAPPED;
      default: s_nxt.st = ST_IDLE;
    endcase

    // Hot-swap: lever edges raise the event line, held until serviced
    s_nxt.lever_d = pins_s[0];
    if (cpci && s_r.st == ST_STRAPPED && pins_s[0] != s_r.lever_d)
    begin
      set[pins_s[0] ? sideband_pkg::EV_LEVER_RISE
                    : sideband_pkg::EV_LEVER_FALL] = 1'b1;
    end

    // Config cycle blocked in RAID mode when alternate grant absent
    if (zcr && cfg_cycle_i && !grant_alt)
    begin
      set[sideband_pkg::EV_CFG_BLOCK] = 1'b1;
    end

    // AXI write
    if (s_axi_awvalid && !s_r.aw_got)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_r.w_got)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    ctrl[sideband_pkg::CTRL_LED] = s_r.led;
    ctrl[sideband_pkg::CTRL_SRC_IRQ] = s_r.src_irq;
    himr[sideband_pkg::ROUTE_MSB:sideband_pkg::ROUTE_LSB] = s_r.route;
    himr[sideband_pkg::EV_W-1:0] = s_r.mask;
    if (do_w)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = sideband_pkg::RESP_OKAY;
      case (s_r.awaddr)
        sideband_pkg::OFF_CTRL:
        begin
          wv = wmerge(ctrl, s_r.wdata, s_r.wstrb);
          s_nxt.led = wv[sideband_pkg::CTRL_LED];
          s_nxt.src_irq = wv[sideband_pkg::CTRL_SRC_IRQ];
          // Only host servicing releases the event line
          if (wv[sideband_pkg::CTRL_EVT_CLR])
          begin
            s_nxt.event_held = 1'b0;
          end
        end
        sideband_pkg::OFF_IRQ_MASK:
        begin
          wv = wmerge({29'h0000_0000, s_r.mask}, s_r.wdata, s_r.wstrb);
          s_nxt.mask = wv[sideband_pkg::EV_W-1:0];
        end
        sideband_pkg::OFF_HIMR:
        begin
          wv = wmerge(himr, s_r.wdata, s_r.wstrb);
          s_nxt.route =
            wv[sideband_pkg::ROUTE_MSB:sideband_pkg::ROUTE_LSB];
        end
        sideband_pkg::OFF_STAT, sideband_pkg::OFF_IRQ_STAT: ;
        default: s_nxt.bresp = sideband_pkg::RESP_SLVERR;
      endcase
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // AXI read; interrupt status read clears sticky bits, new events win
    if (do_r)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rresp = sideband_pkg::RESP_OKAY;
      s_nxt.rdata = '0;
      case (s_axi_araddr)
        sideband_pkg::OFF_CTRL: s_nxt.rdata = ctrl;
        sideband_pkg::OFF_STAT:
          s_nxt.rdata = {26'h000_0000, pins_s[0], s_r.event_held,
                         s_r.strap.wide_n, s_r.strap.cpci_n,
                         s_r.strap.zcr_n, pins_s[6]};
        sideband_pkg::OFF_IRQ_STAT:
        begin
          s_nxt.rdata = {29'h0000_0000, s_r.ev};
          s_nxt.ev = sideband_pkg::EV_RST;
        end
        sideband_pkg::OFF_IRQ_MASK:
          s_nxt.rdata = {29'h0000_0000, s_r.mask};
        sideband_pkg::OFF_HIMR: s_nxt.rdata = himr;
        default: s_nxt.rresp = sideband_pkg::RESP_SLVERR;
      endcase
    end
    if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
    s_nxt.ev = s_nxt.ev | set;
    if (set[sideband_pkg::EV_LEVER_RISE] || set[sideband_pkg::EV_LEVER_FALL])
    begin
      s_nxt.event_held = 1'b1;
    end

    // Interrupt routing; alternate line unused in standard mode
    s_nxt.po.alt_irq_oe = zcr && route_alt && irq_req;
    // RAID mode drops the standard interrupt
    s_nxt.po.inta_n = !(irq_req && route_std && !zcr);
    s_nxt.po.event_oe = cpci && s_r.event_held;
    s_nxt.po.led_n = !s_r.led;
    // Grant source follows mode; alt grant ignored outside RAID mode
    s_nxt.po.grant = zcr ? grant_alt : grant_std;
    s_nxt.po.cfg_ok = cfg_cycle_i && (!zcr || grant_alt);
    s_nxt.irq = |(s_r.ev & s_r.mask);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.strap <= '{zcr_n: 1'b1, cpci_n: 1'b1, wide_n: 1'b1};
      s_r.route <= sideband_pkg::HIMR_RST[9:8];
      s_r.led <= sideband_pkg::CTRL_RST[0];
      s_r.po <= '{inta_n: 1'b1, alt_irq_oe: 1'b0, event_oe: 1'b0,
                  led_n: 1'b1, cfg_ok: 1'b0, grant: 1'b0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign inta_n_o = s_r.po.inta_n;
  assign alt_irq_n_o = 1'b0;
  assign alt_irq_n_oe_o = s_r.po.alt_irq_oe;
  assign hotswap_event_n_o = 1'b0;
  assign hotswap_event_n_oe_o = s_r.po.event_oe;
  assign blue_status_led_n_o = s_r.po.led_n;
  assign cfg_accept_o = s_r.po.cfg_ok;
  assign bus_grant_o = s_r.po.grant;
  assign wide_bus_o = !s_r.strap.wide_n;
  assign compact_mode_o = !s_r.strap.cpci_n;
  assign irq_o = s_r.irq;
  assign s_axi_awready = !s_r.aw_got;
  assign s_axi_wready = !s_r.w_got;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;
endmodule

// File: dv/far_host_model.sv
`timescale 1ns/1ps
module far_host_model (
  // Clock and grant request from the bench
  input wire logic clk_i,
  input wire logic grant_req_i,
  // Open-drain drivers of the device
  input wire logic alt_irq_n_i,
  input wire logic alt_irq_n_oe_i,
  input wire logic event_n_i,
  input wire logic event_n_oe_i,
  // Resolved wires and alternate grant
  output logic alt_irq_line_o,
  output logic event_line_o,
  output logic alt_grant_n_o = 1'h1
);
  // Pull-ups hold a released line high
  assign alt_irq_line_o = alt_irq_n_oe_i ? alt_irq_n_i : 1'h1;
  assign event_line_o = event_n_oe_i ? event_n_i : 1'h1;
  always @(posedge clk_i)
  begin
    alt_grant_n_o <= !grant_req_i;
  end
endmodule

// File: dv/sideband_monitor.sv
`timescale 1ns/1ps
module sideband_monitor (
  // Clock, reset and straps
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  input wire logic zero_chan_raid_en_n_i,
  input wire logic compact_bus_en_n_i,
  input wire logic wide_bus_en_n_i,
  // Far side inputs
  input wire logic alt_grant_n_i,
  input wire logic cfg_cycle_i,
  input wire logic dev_irq_i,
  input wire logic s_axi_wvalid,
  // Device outputs
  input wire logic cfg_accept_o,
  input wire logic hotswap_event_n_o,
  input wire logic hotswap_event_n_oe_o,
  input wire logic wide_bus_o,
  input wire logic compact_mode_o,
  input wire logic inta_n_o,
  input wire logic alt_irq_n_o,
  input wire logic alt_irq_n_oe_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!arst_n_i);
  sequence irq_held_s;
    (dev_irq_i && zero_chan_raid_en_n_i)[*4];
  endsequence
  sequence grant_off_s;
    (alt_grant_n_i && !zero_chan_raid_en_n_i)[*5];
  endsequence
  // Straps need a few cycles after reset before they show
  a_strap_view: assert property ($rose(arst_n_i) |-> ##8
    (wide_bus_o != wide_bus_en_n_i && compact_mode_o != compact_bus_en_n_i))
    else $error("strap outputs wrong");
  a_alt_raid_off: assert property (
    zero_chan_raid_en_n_i |-> !alt_irq_n_oe_o) else $error("alt irq driven");
  a_open_drain: assert property (
    !(alt_irq_n_oe_o && alt_irq_n_o) &&
    !(hotswap_event_n_oe_o && hotswap_event_n_o)) else $error("drives high");
  a_inta_raid_on: assert property (
    !zero_chan_raid_en_n_i |-> inta_n_o) else $error("inta used in raid");
  a_inta_std: assert property (irq_held_s |-> !inta_n_o)
    else $error("inta not asserted");
  a_event_hold: assert property ($fell(hotswap_event_n_oe_o) |->
    $past(s_axi_wvalid, 1) || $past(s_axi_wvalid, 2) ||
    $past(s_axi_wvalid, 3)) else $error("event released on its own");
  a_cfg_block: assert property (grant_off_s |-> !cfg_accept_o)
    else $error("config accepted without grant");
  a_cfg_free: assert property (
    (cfg_cycle_i && zero_chan_raid_en_n_i)[*3] |-> cfg_accept_o)
    else $error("config refused in std mode");
endmodule
bind pci_sideband_zcr_hotswap sideband_monitor mon_u (.*);

// File: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i = 1'h0;
  logic arst_n_i = 1'h0;
  logic zero_chan_raid_en_n_i = 1'h1;
  logic compact_bus_en_n_i = 1'h0;
  logic wide_bus_en_n_i = 1'h0;
  logic std_grant_n_i = 1'h1;
  logic cfg_cycle_i = 1'h0;
  logic hotswap_lever_i = 1'h0;
  logic dev_irq_i = 1'h0;
  logic grant_req = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic alt_grant_n_i, hotswap_event_n_i, alt_line, cfg_accept_o;
  logic bus_grant_o, hotswap_event_n_o, hotswap_event_n_oe_o, irq_o;
  logic blue_status_led_n_o, wide_bus_o, compact_mode_o, inta_n_o;
  logic alt_irq_n_o, alt_irq_n_oe_o, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd;
  int bad_count = 0;
  int samples_checked = 0;

  pci_sideband_zcr_hotswap dut_u (.*);
  far_host_model host_u (
    .clk_i(clk_sys_i),
    .grant_req_i(grant_req),
    .alt_irq_n_i(alt_irq_n_o),
    .alt_irq_n_oe_i(alt_irq_n_oe_o),
    .event_n_i(hotswap_event_n_o),
    .event_n_oe_i(hotswap_event_n_oe_o),
    .alt_irq_line_o(alt_line),
    .event_line_o(hotswap_event_n_i),
    .alt_grant_n_o(alt_grant_n_i)
  );

  initial forever #10 clk_sys_i = ~clk_sys_i;

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid && n < 64);
    if (n >= 64) bad_count++;
    rsp = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tick(1);
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid && n < 64);
    if (n >= 64) bad_count++;
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tick(1);
  endtask

  task automatic do_reset();
    arst_n_i <= 1'h0;
    tick(3);
    arst_n_i <= 1'h1;
    tick(8);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #200000;
    bad_count++;
    wrap_up();
  end

  initial
  begin
    do_reset();
    axr(sideband_pkg::OFF_STAT);
    chk("stat", 32'h0000_0003, rd);
    chk("wide", 1, wide_bus_o);
    chk("cpci", 1, compact_mode_o);
    axr(8'h40);
    chk("rresp", 32'(sideband_pkg::RESP_SLVERR), 32'(rsp));
    axw(8'h40, 32'h0000_0001);
    chk("bresp", 32'(sideband_pkg::RESP_SLVERR), 32'(rsp));
    axw(sideband_pkg::OFF_CTRL, 32'h0000_0001);
    tick(2);
    chk("led", 0, blue_status_led_n_o);
    axw(sideband_pkg::OFF_CTRL, 32'h0000_0000);
    tick(2);
    chk("led", 1, blue_status_led_n_o);
    axw(sideband_pkg::OFF_IRQ_MASK, 32'h0000_0007);
    hotswap_lever_i <= 1'h1;
    tick(8);
    chk("event", 0, hotswap_event_n_i);
    chk("irq", 1, irq_o);
    axr(sideband_pkg::OFF_IRQ_STAT);
    chk("istat", 32'h0000_0001, rd);
    tick(2);
    chk("irq", 0, irq_o);
    axw(sideband_pkg::OFF_IRQ_MASK, 32'h0000_0000);
    hotswap_lever_i <= 1'h0;
    tick(8);
    chk("irq", 0, irq_o);
    axr(sideband_pkg::OFF_IRQ_STAT);
    chk("istat", 32'h0000_0002, rd);
    tick(20);
    chk("event", 0, hotswap_event_n_i);
    axw(sideband_pkg::OFF_CTRL, 32'h0000_0002);
    tick(3);
    chk("event", 1, hotswap_event_n_i);
    axw(sideband_pkg::OFF_HIMR, 32'h0000_0100);
    dev_irq_i <= 1'h1;
    std_grant_n_i <= 1'h0;
    cfg_cycle_i <= 1'h1;
    tick(6);
    chk("inta", 0, inta_n_o);
    chk("alt", 1, alt_line);
    chk("grant", 1, bus_grant_o);
    chk("cfg", 1, cfg_accept_o);
    dev_irq_i <= 1'h0;
    cfg_cycle_i <= 1'h0;
    axw(sideband_pkg::OFF_CTRL, 32'h0000_0004);
    tick(3);
    chk("swirq", 0, inta_n_o);
    axw(sideband_pkg::OFF_CTRL, 32'h0000_0000);
    tick(3);
    chk("swirq", 1, inta_n_o);
    // Strap moves only while reset is held, since it is caught once
    arst_n_i <= 1'h0;
    tick(1);
    zero_chan_raid_en_n_i <= 1'h0;
    compact_bus_en_n_i <= 1'h1;
    wide_bus_en_n_i <= 1'h1;
    do_reset();
    axr(sideband_pkg::OFF_STAT);
    chk("stat", 32'h0000_000d, rd);
    chk("wide", 0, wide_bus_o);
    chk("cpci", 0, compact_mode_o);
    hotswap_lever_i <= 1'h1;
    tick(8);
    chk("event", 1, hotswap_event_n_i);
    for (int m = 0; m < 4; m++)
    begin
      axw(sideband_pkg::OFF_HIMR, 32'(m) << 8);
      dev_irq_i <= 1'h1;
      tick(6);
      chk("alt", (m == 1 || m == 2) ? 0 : 1, alt_line);
      chk("inta", 1, inta_n_o);
      dev_irq_i <= 1'h0;
      tick(6);
      chk("alt", 1, alt_line);
    end
    cfg_cycle_i <= 1'h1;
    tick(6);
    chk("cfg", 0, cfg_accept_o);
    chk("grant", 0, bus_grant_o);
    grant_req <= 1'h1;
    tick(6);
    chk("cfg", 1, cfg_accept_o);
    chk("grant", 1, bus_grant_o);
    cfg_cycle_i <= 1'h0;
    grant_req <= 1'h0;
    axr(sideband_pkg::OFF_IRQ_STAT);
    chk("blocked", 32'h0000_0004, rd);
    wrap_up();
  end
endmodule
